// ### src/drs_pkg.sv
// constants for the result status bytes block
package drs_pkg;
	// termination class codes, top two bits of the first byte
	localparam logic [1:0] FIN_NORMAL   = 2'h0;
	localparam logic [1:0] FIN_FAILED   = 2'h1;
	localparam logic [1:0] FIN_REJECTED = 2'h2;
	localparam logic [1:0] FIN_READY_CH = 2'h3;
	// first byte field positions
	localparam int B0_CODE_LO  = 6;
	localparam int B0_POS_DONE = 5;
	localparam int B0_EQ_FAULT = 4;
	localparam int B0_UNREADY  = 3;
	localparam int B0_HEAD     = 2;
	// second byte field positions
	localparam int B1_END_CYL  = 7;
	localparam int B1_CRC      = 5;
	localparam int B1_OVERRUN  = 4;
	localparam int B1_MISSING  = 2;
	localparam int B1_WPROT    = 1;
	localparam int B1_ID_ABS   = 0;
	// third byte field positions
	localparam int B2_DELETED  = 6;
	localparam int B2_PAY_CRC  = 5;
	localparam int B2_TRK_MIS  = 4;
	localparam int B2_CMP_EQ   = 3;
	localparam int B2_CMP_UN   = 2;
	localparam int B2_BAD_TRK  = 1;
	localparam int B2_PAY_ABS  = 0;
	// reset values
	localparam logic [7:0] RESULT_RESET = 8'h00;
	// return-to-zero step limit and the bad track marker
	localparam logic [6:0] RTZ_STEP_LIMIT = 7'h4d;
	localparam logic [7:0] BAD_TRACK_CODE = 8'hff;
	// index pulses allowed before the id tag is declared absent
	localparam logic [1:0] INDEX_LIMIT = 2'h2;
	// result byte selector
	localparam logic [1:0] SEL_FIRST  = 2'h0;
	localparam logic [1:0] SEL_SECOND = 2'h1;
	localparam logic [1:0] SEL_THIRD  = 2'h2;
endpackage : drs_pkg

// ### src/drs_result_status.sv
// result status bytes of a floppy disk controller
`timescale 1ns/1ps
module drs_result_status (
	input  wire logic       clk,
	input  wire logic       nrst,
	// command sequencer events
	input  wire logic       cmd_accept,
	input  wire logic       cmd_is_rw,
	input  wire logic       cmd_is_write,
	input  wire logic       cmd_is_rtz,
	input  wire logic       cmd_is_id_read,
	input  wire logic       cmd_is_diag,
	input  wire logic       cmd_is_scan,
	input  wire logic       cmd_is_del_read,
	input  wire logic       cmd_side,
	input  wire logic [1:0] cmd_unit,
	input  wire logic       cmd_invalid,
	input  wire logic       exec_done,
	input  wire logic       seek_done,
	input  wire logic       step_pulse,
	input  wire logic       index_pulse,
	input  wire logic       sector_past_end,
	input  wire logic       id_crc_err,
	input  wire logic       data_crc_err,
	input  wire logic       byte_overrun,
	input  wire logic       sector_not_found,
	input  wire logic       id_tag_found,
	input  wire logic       id_read_err,
	input  wire logic       payload_tag_missing,
	input  wire logic       data_tag_seen,
	input  wire logic       deleted_tag_seen,
	input  wire logic       track_read_valid,
	input  wire logic [7:0] track_read,
	input  wire logic [7:0] target_track,
	input  wire logic       compare_equal,
	input  wire logic       compare_unmet,
	// drive interface
	input  wire logic       drive_fault,
	input  wire logic       drive_ready,
	input  wire logic       drive_track_zero,
	input  wire logic       drive_write_protect,
	input  wire logic       drive_two_sided,
	input  wire logic       head_side,
	input  wire logic [1:0] drive_unit,
	// result reading
	input  wire logic       result_rd,
	input  wire logic [1:0] result_sel,
	output logic            result_phase,
	output logic      [7:0] result_data,
	output logic            abort_req
);

	// ----------------------------------------
	// state and flag storage
	// ----------------------------------------
	typedef enum logic [1:0] {DRS_IDLE, DRS_EXEC, DRS_RESULT} drs_state_e;

	// phase state
	drs_state_e  state;
	drs_state_e  next_state;

	// first byte fields
	logic [1:0]  fin_code;
	logic        pos_done;
	logic        equipment_fault_flag;
	logic        drive_unready_flag;
	logic        head_side_bit;
	logic        drive_select_bit0;
	logic        drive_select_bit1;

	// second and third byte flags
	logic [7:0]  err1;
	logic [6:0]  err2;

	// search counters and readiness seen at accept
	logic [6:0]  step_cnt;
	logic [1:0]  index_cnt;
	logic        ready_seen;

	// command kind latched at accept
	logic        cmd_rw_q;
	logic        cmd_wr_q;
	logic        cmd_rtz_q;
	logic        cmd_id_q;
	logic        cmd_diag_q;
	logic        cmd_scan_q;
	logic        cmd_del_q;

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	wire logic in_exec;
	wire logic track_mis;
	wire logic bad_track;
	wire logic ready_changed;
	wire logic rtz_fail;
	wire logic unready_start;
	wire logic side_bad;
	wire logic wprot_hit;
	wire logic index_timeout;
	wire logic id_missing;
	wire logic pay_missing;
	wire logic sect_miss;
	wire logic del_mismatch;
	wire logic start_fail;
	wire logic fail_event;
	wire logic ev_ok;
	wire logic fin_to_result;

	// phase qualifiers
	assign in_exec = (state == DRS_EXEC);
	assign ev_ok   = in_exec || cmd_accept; // events count in exec or with the accept

	// cylinder read back against the target latch
	assign track_mis = track_read_valid && (track_read != target_track);
	assign bad_track = track_mis && (track_read == drs_pkg::BAD_TRACK_CODE);

	// readiness against the level seen at accept
	assign ready_changed = in_exec && (drive_ready != ready_seen);

	// return to zero gives up on the last allowed step
	assign rtz_fail = cmd_rtz_q && step_pulse && !drive_track_zero &&
	                  (step_cnt == drs_pkg::RTZ_STEP_LIMIT - 7'h01);

	// checks made as a read or write is taken
	assign unready_start = cmd_accept && cmd_is_rw && !drive_ready;
	assign side_bad      = cmd_accept && cmd_is_rw && cmd_side && !drive_two_sided;

	// protect seen as a write is taken or while it runs
	assign wprot_hit = drive_write_protect &&
	                   ((cmd_accept && cmd_is_write) || (in_exec && cmd_wr_q));

	// address tag search bounded by index pulses
	assign index_timeout = in_exec && index_pulse && !id_tag_found &&
	                       (index_cnt == drs_pkg::INDEX_LIMIT - 2'h1);
	assign id_missing    = index_timeout;
	assign pay_missing   = payload_tag_missing && !cmd_id_q;

	// sector search failures per command kind
	assign sect_miss = (sector_not_found && (cmd_rw_q || cmd_scan_q || cmd_diag_q)) ||
	                   (id_read_err && cmd_id_q) || track_mis;

	// data tag of the wrong kind for the command
	assign del_mismatch = (deleted_tag_seen && !cmd_del_q && (cmd_rw_q || cmd_scan_q)) ||
	                      (data_tag_seen && cmd_del_q);

	// failures known the moment a command is taken
	assign start_fail = unready_start || side_bad || wprot_hit || drive_fault;

	// anything other than a ready change that ends execution early
	assign fail_event = unready_start || side_bad || wprot_hit || rtz_fail || drive_fault ||
	                    id_missing || sect_miss || pay_missing || sector_past_end ||
	                    id_crc_err || data_crc_err || byte_overrun;

	// early end, result flag and the end of execution
	assign abort_req     = in_exec && (fail_event || ready_changed);
	assign result_phase  = (state == DRS_RESULT);
	assign fin_to_result = in_exec && (next_state == DRS_RESULT);

	// ----------------------------------------
	// phase sequencing
	// ----------------------------------------
	// next phase from the current one and this cycle's events
	always_comb begin
		next_state = state;
		case (state)
			DRS_IDLE:   if (cmd_accept) next_state = cmd_invalid ? DRS_RESULT : DRS_EXEC;
			DRS_EXEC:   if (exec_done || abort_req) next_state = DRS_RESULT;
			DRS_RESULT: if (cmd_accept) next_state = cmd_invalid ? DRS_RESULT : DRS_EXEC;
			default:    next_state = DRS_IDLE;
		endcase
	end

	// phase register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) state <= DRS_IDLE;
		else state <= next_state;
	end

	// ----------------------------------------
	// latched command kind and counters
	// ----------------------------------------
	// command kind and readiness held for the whole command
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{cmd_rw_q, cmd_wr_q, cmd_rtz_q, cmd_id_q, cmd_diag_q, cmd_scan_q, cmd_del_q} <= 7'h00;
			ready_seen <= 1'b0;
		end else if (cmd_accept) begin
			cmd_rw_q   <= cmd_is_rw;
			cmd_wr_q   <= cmd_is_write;
			cmd_rtz_q  <= cmd_is_rtz;
			cmd_id_q   <= cmd_is_id_read;
			cmd_diag_q <= cmd_is_diag;
			cmd_scan_q <= cmd_is_scan;
			cmd_del_q  <= cmd_is_del_read;
			ready_seen <= drive_ready;
		end
	end

	// step and index counters restart with each command
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			step_cnt  <= 7'h00;
			index_cnt <= 2'h0;
		end else if (cmd_accept || id_tag_found) begin
			step_cnt  <= cmd_accept ? 7'h00 : step_cnt;
			index_cnt <= 2'h0;
		end else if (in_exec) begin
			if (step_pulse && cmd_rtz_q) step_cnt <= step_cnt + 7'h01;
			if (index_pulse) index_cnt <= index_cnt + 2'h1;
		end
	end

	// ----------------------------------------
	// first byte: class, completion, faults, unit
	// ----------------------------------------
	// class code and drive flags, reloaded by each new command
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fin_code <= drs_pkg::FIN_NORMAL;
			pos_done <= 1'b0;
			equipment_fault_flag <= 1'b0;
			drive_unready_flag   <= 1'b0;
			head_side_bit        <= 1'b0;
			drive_select_bit0    <= 1'b0;
			drive_select_bit1    <= 1'b0;
		end else begin
			if (cmd_accept) begin
				if (cmd_invalid) fin_code <= drs_pkg::FIN_REJECTED;
				else if (start_fail) fin_code <= drs_pkg::FIN_FAILED;
				else fin_code <= drs_pkg::FIN_NORMAL;
				pos_done <= seek_done;
				equipment_fault_flag <= drive_fault;
				drive_unready_flag   <= unready_start || side_bad;
				head_side_bit        <= cmd_side;
				drive_select_bit0    <= cmd_unit[0];
				drive_select_bit1    <= cmd_unit[1];
			end else if (in_exec) begin
				if (ready_changed) fin_code <= drs_pkg::FIN_READY_CH;
				else if (fail_event) fin_code <= drs_pkg::FIN_FAILED;
				if (seek_done) pos_done <= 1'b1;
				if (drive_fault || rtz_fail) equipment_fault_flag <= 1'b1;
			end
			// head and unit captured as the command ends
			if (fin_to_result) begin
				head_side_bit     <= head_side;
				drive_select_bit0 <= drive_unit[0];
				drive_select_bit1 <= drive_unit[1];
			end
		end
	end

	// ----------------------------------------
	// second and third byte error flags
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err1 <= drs_pkg::RESULT_RESET;
			err2 <= 7'h00;
		end else if (ev_ok) begin
			// clear on accept, but an event in the same cycle still sets, except sect_miss, which sets only in exec
			if (cmd_accept) begin
				err1 <= 8'h00;
				err2 <= 7'h00;
			end
			// second byte
			if (sector_past_end) err1[drs_pkg::B1_END_CYL] <= 1'b1;
			if (id_crc_err || data_crc_err) err1[drs_pkg::B1_CRC] <= 1'b1;
			if (byte_overrun) err1[drs_pkg::B1_OVERRUN] <= 1'b1;
			if (in_exec && sect_miss) err1[drs_pkg::B1_MISSING] <= 1'b1;
			if (wprot_hit) err1[drs_pkg::B1_WPROT] <= 1'b1;
			if (id_missing || pay_missing) err1[drs_pkg::B1_ID_ABS] <= 1'b1;
			// third byte
			if (del_mismatch) err2[drs_pkg::B2_DELETED] <= 1'b1;
			if (data_crc_err) err2[drs_pkg::B2_PAY_CRC] <= 1'b1;
			if (track_mis) err2[drs_pkg::B2_TRK_MIS] <= 1'b1;
			if (compare_equal && cmd_scan_q) err2[drs_pkg::B2_CMP_EQ] <= 1'b1;
			if (compare_unmet && cmd_scan_q) err2[drs_pkg::B2_CMP_UN] <= 1'b1;
			if (bad_track) err2[drs_pkg::B2_BAD_TRK] <= 1'b1;
			if (pay_missing) err2[drs_pkg::B2_PAY_ABS] <= 1'b1;
		end
	end

	// ----------------------------------------
	// result byte assembly and read port
	// ----------------------------------------
	wire logic [7:0] byte_first;
	wire logic [7:0] byte_second;
	wire logic [7:0] byte_third;
	wire logic [7:0] sel_byte;

	// first byte: class code on top, then completion, faults, head and unit
	assign byte_first[7:drs_pkg::B0_CODE_LO] = fin_code;
	assign byte_first[drs_pkg::B0_POS_DONE]  = pos_done;
	assign byte_first[drs_pkg::B0_EQ_FAULT]  = equipment_fault_flag;
	assign byte_first[drs_pkg::B0_UNREADY]   = drive_unready_flag;
	assign byte_first[drs_pkg::B0_HEAD]      = head_side_bit;
	assign byte_first[1]                     = drive_select_bit1;
	assign byte_first[0]                     = drive_select_bit0;

	// second byte: unused bits tied low
	assign byte_second = {err1[7], 1'b0, err1[5:4], 1'b0, err1[2:0]};
	// third byte: top bit unused
	assign byte_third  = {1'b0, err2[6:0]};

	// byte selection for the read port; the spare code reads zero
	assign sel_byte = (result_sel == drs_pkg::SEL_FIRST)  ? byte_first :
	                  (result_sel == drs_pkg::SEL_SECOND) ? byte_second :
	                  (result_sel == drs_pkg::SEL_THIRD)  ? byte_third : 8'h00;

	// data leaves a flop, only while in the result phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) result_data <= drs_pkg::RESULT_RESET;
		else if (result_rd && result_phase) result_data <= sel_byte;
		else if (!result_phase) result_data <= 8'h00;
	end

endmodule : drs_result_status

// ### sim/drs_result_status_assertions.sv
// concurrent checks on the result status block ports
`timescale 1ns/1ps
module drs_result_status_assertions (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       cmd_accept,
	input wire logic       cmd_invalid,
	input wire logic       exec_done,
	input wire logic       data_crc_err,
	input wire logic       drive_ready,
	input wire logic       result_rd,
	input wire logic [1:0] result_sel,
	input wire logic       result_phase,
	input wire logic [7:0] result_data,
	input wire logic       abort_req
);
	logic in_exec;
	logic ready_cap;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------
	// exec tracker
	// ----------------
	// mirrors the exec state; an abort in the accept cycle never opens it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_exec   <= 1'b0;
			ready_cap <= 1'b0;
		end else if (cmd_accept) begin
			in_exec   <= !cmd_invalid && !abort_req;
			ready_cap <= drive_ready;
		end else if (exec_done || abort_req || result_phase) begin
			in_exec <= 1'b0;
		end
	end
	// ----------------
	// properties
	// ----------------
	property p_invalid; cmd_accept && cmd_invalid |=> result_phase; endproperty
	a_invalid: assert property (p_invalid) else $error("rejected opcode gave no result");
	property p_done; in_exec && exec_done |=> result_phase; endproperty
	a_done: assert property (p_done) else $error("finish gave no result");
	property p_crc; in_exec && data_crc_err |-> abort_req; endproperty
	a_crc: assert property (p_crc) else $error("crc fault did not abort");
	property p_ready; in_exec && (drive_ready != ready_cap) |-> abort_req; endproperty
	a_ready: assert property (p_ready) else $error("ready change did not abort");
	property p_quiet; abort_req && !cmd_accept |-> !result_phase; endproperty
	a_quiet: assert property (p_quiet) else $error("abort outside exec");
	property p_hold; result_phase && !cmd_accept |=> result_phase; endproperty
	a_hold: assert property (p_hold) else $error("result phase dropped");
	property p_stable; result_phase && !result_rd ##1 result_phase |-> $stable(result_data); endproperty
	a_stable: assert property (p_stable) else $error("byte moved without a read");
	property p_idle; !result_phase [*2] |-> result_data == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("byte shown outside result");
	property p_spare; result_phase && result_rd && result_sel == 2'h3 |=> result_data == 8'h00; endproperty
	a_spare: assert property (p_spare) else $error("spare select read nonzero");
endmodule : drs_result_status_assertions

bind drs_result_status drs_result_status_assertions chk_u (.clk, .nrst, .cmd_accept, .cmd_invalid, .exec_done,
	.data_crc_err, .drive_ready, .result_rd, .result_sel, .result_phase, .result_data, .abort_req);

// ### sim/drs_host_model.sv
// behavioural host that reads the result bytes
`timescale 1ns/1ps
module drs_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] result_data,
	output logic            result_rd,
	output logic      [1:0] result_sel
);
	initial begin
		result_rd  = 1'b0;
		result_sel = 2'h0;
	end
	// one strobe after gap plus one idle cycles; select scrambled once released
	task automatic read_byte(input logic [1:0] sel, input int gap, output logic [7:0] data);
		repeat (gap + 1) @(posedge clk);
		#1 result_rd = 1'b1;
		result_sel = sel;
		@(posedge clk);
		#1 result_rd = 1'b0;
		result_sel = ~sel;
		data = result_data;
	endtask : read_byte
endmodule : drs_host_model

// ### sim/tb.sv
// testbench for the result status block
`timescale 1ns/1ps
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin err_count++; $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module tb;
	logic        clk, nrst, acc, side, inv, dn, sk, stp, idx, tv, flt, rdy, tz, wp, two, hs;
	logic [6:0]  kind;
	logic [11:0] ev;
	logic [1:0]  unit, hunit;
	logic [7:0]  trd, b;
	wire         rd, ph;
	wire  [1:0]  sel;
	wire  [7:0]  rdata;
	int          err_count, total_checks;
	drs_result_status dut_u (.clk(clk), .nrst(nrst), .cmd_accept(acc), .cmd_is_rw(kind[6]), .cmd_is_write(kind[5]),
		.cmd_is_rtz(kind[4]), .cmd_is_id_read(kind[3]), .cmd_is_diag(kind[2]), .cmd_is_scan(kind[1]),
		.cmd_is_del_read(kind[0]), .cmd_side(side), .cmd_unit(unit), .cmd_invalid(inv), .exec_done(dn),
		.seek_done(sk), .step_pulse(stp), .index_pulse(idx), .sector_past_end(ev[11]), .id_crc_err(ev[10]),
		.data_crc_err(ev[9]), .byte_overrun(ev[8]), .sector_not_found(ev[7]), .id_tag_found(ev[6]),
		.id_read_err(ev[5]), .payload_tag_missing(ev[4]), .data_tag_seen(ev[3]), .deleted_tag_seen(ev[2]),
		.track_read_valid(tv), .track_read(trd), .target_track(8'h03), .compare_equal(ev[1]), .compare_unmet(ev[0]),
		.drive_fault(flt), .drive_ready(rdy), .drive_track_zero(tz), .drive_write_protect(wp),
		.drive_two_sided(two), .head_side(hs), .drive_unit(hunit), .result_rd(rd), .result_sel(sel),
		.result_phase(ph), .result_data(rdata), .abort_req());
	drs_host_model host_u (.clk(clk), .result_data(rdata), .result_rd(rd), .result_sel(sel));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic start(input logic [6:0] k, input logic s, input logic [1:0] u, input logic iv);
		@(posedge clk);
		#1 acc = 1'b1;
		{kind, side, unit, inv, hs, hunit} = {k, s, u, iv, s, u};
		@(posedge clk);
		#1 acc = 1'b0;
		{kind, inv} = '0;
	endtask : start
	// waits for the result phase, ending exec by hand if nothing aborted it
	task automatic finish;
		for (int i = 0; i < 12 && ph !== 1'b1; i++) begin
			if (i == 4) dn = 1'b1;
			@(posedge clk);
			#1 dn = 1'b0;
		end
		if (ph !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: no result phase", $time);
			complete_run();
		end
	endtask : finish
	task automatic expect_byte(input logic [1:0] s, input logic [7:0] w, input int gap);
		host_u.read_byte(s, gap, b);
		`CHK(b, w)
	endtask : expect_byte
	// one event (or index pair, protect, track read) then second and third bytes
	task automatic evcase(input logic [6:0] k, input logic [11:0] e, input int x, input logic [7:0] s, input logic [7:0] t);
		wp = (x == 2);
		start(k, 1'b0, 2'h1, 1'b0);
		{ev, idx, tv} = {e, x == 1, x > 2};
		trd = (x == 4) ? 8'hff : 8'h05;
		@(posedge clk);
		#1 {ev, idx, tv} = '0;
		@(posedge clk);
		#1 idx = (x == 1);
		@(posedge clk);
		#1 idx = 1'b0;
		finish();
		expect_byte(2'h1, s, 0);
		expect_byte(2'h2, t, 1);
		wp = 1'b0;
	endtask : evcase
	task automatic t_events;
		evcase(7'h40, 12'h800, 0, 8'h80, 8'h00);
		evcase(7'h40, 12'h400, 0, 8'h20, 8'h00);
		evcase(7'h40, 12'h200, 0, 8'h20, 8'h20);
		evcase(7'h40, 12'h100, 0, 8'h10, 8'h00);
		evcase(7'h40, 12'h080, 0, 8'h04, 8'h00);
		evcase(7'h08, 12'h020, 0, 8'h04, 8'h00);
		evcase(7'h04, 12'h080, 0, 8'h04, 8'h00);
		evcase(7'h40, 12'h010, 0, 8'h01, 8'h01);
		evcase(7'h40, 12'h004, 0, 8'h00, 8'h40);
		evcase(7'h41, 12'h008, 0, 8'h00, 8'h40);
		evcase(7'h02, 12'h002, 0, 8'h00, 8'h08);
		evcase(7'h02, 12'h001, 0, 8'h00, 8'h04);
		evcase(7'h60, 12'h000, 2, 8'h02, 8'h00);
		evcase(7'h40, 12'h000, 1, 8'h01, 8'h00);
		evcase(7'h40, 12'h000, 3, 8'h04, 8'h10);
		evcase(7'h40, 12'h000, 4, 8'h04, 8'h12);
	endtask : t_events
	task automatic t_rtz;
		tz = 1'b0;
		start(7'h10, 1'b0, 2'h2, 1'b0);
		for (int i = 1; i <= 77; i++) begin
			if (i == 77) `CHK(ph, 1'b0)
			stp = 1'b1;
			@(posedge clk);
			#1 stp = 1'b0;
			@(posedge clk);
			#1;
		end
		finish();
		expect_byte(2'h0, 8'h52, 0);
		expect_byte(2'h2, 8'h00, 0);
		tz = 1'b1;
	endtask : t_rtz
	task automatic t_ready;
		rdy = 1'b0;
		start(7'h40, 1'b0, 2'h0, 1'b0);
		finish();
		expect_byte(2'h0, 8'h48, 0);
		{rdy, two} = 2'b10;
		start(7'h40, 1'b1, 2'h1, 1'b0);
		finish();
		expect_byte(2'h0, 8'h4d, 2);
		two = 1'b1;
		start(7'h40, 1'b0, 2'h3, 1'b0);
		rdy = 1'b0;
		finish();
		rdy = 1'b1;
		expect_byte(2'h0, 8'hc3, 1);
		start(7'h40, 1'b0, 2'h2, 1'b1);
		finish();
		expect_byte(2'h0, 8'h82, 0);
	endtask : t_ready
	task automatic t_seek_normal;
		start(7'h00, 1'b1, 2'h1, 1'b0);
		sk = 1'b1;
		@(posedge clk);
		#1 sk = 1'b0;
		finish();
		expect_byte(2'h0, 8'h25, 0);
		start(7'h40, 1'b0, 2'h0, 1'b0);
		{hs, hunit} = 3'b110;
		finish();
		expect_byte(2'h0, 8'h06, 0);
		expect_byte(2'h1, 8'h00, 0);
		expect_byte(2'h2, 8'h00, 0);
		expect_byte(2'h3, 8'h00, 0);
	endtask : t_seek_normal
	initial begin
		{nrst, acc, side, inv, dn, sk, stp, idx, tv, flt, wp, hs, kind, ev, unit, hunit, trd} = '0;
		{rdy, tz, two} = 3'b111;
		err_count = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		expect_byte(2'h0, 8'h00, 3);
		t_events();
		t_rtz();
		t_ready();
		t_seek_normal();
		complete_run();
	end
endmodule : tb
